// [bench/tcm_far_side.sv]
// tcm_far_side: timer clock source, adc start counter and pin wire
// assumes the bench clock; run and div are set by the bench
`timescale 1ns/1ps
module tcm_far_side (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // tick control
  input  wire logic       run,
  input  wire logic [7:0] div,
  // from the unit
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  input  wire logic       adc_go_set,
  // to the unit and bench
  output logic            timer_tick,
  output logic            pin_level,
  output logic      [7:0] adc_starts
);
  logic [7:0] cnt_reg;
  logic       last_reg;

  // ==========================================================
  // synchronous one-cycle tick every div+1 clocks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg    <= 8'h00;
      timer_tick <= 1'b0;
      adc_starts <= 8'h00;
      last_reg   <= 1'b0;
    end else begin
      timer_tick <= run && cnt_reg == 8'h00;
      cnt_reg    <= (cnt_reg == 8'h00) ? div : cnt_reg - 8'h01;
      adc_starts <= adc_go_set ? adc_starts + 8'h01 : adc_starts;
      last_reg   <= pin_level;
    end
  end

  // released pin shows the inverse of its last level
  assign pin_level = pin_oe ? pin_o : ~last_reg;
endmodule

// [bench/timer_compare_match_unit_test.sv]
// timer_compare_match_unit_test: register, compare, trigger and pwm checks
// assumes tcm_top and tcm_far_side; reads are checked from a queue
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module timer_compare_match_unit_test import tcm_pkg::*;;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       pin_direction_bit = 1'b1;
  logic       port_data_latch = 1'b0;
  logic       run = 1'b0;
  logic [7:0] rdata, adc_starts, mon_e;
  logic       tick, pin_o, pin_oe, trig, adc_go, irq, pin_level, rd_d;
  logic [7:0] exp_q[$];
  int         n_fail, checks, cyc;

  tcm_top uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_tick(tick), .pin_direction_bit(pin_direction_bit),
    .port_data_latch(port_data_latch), .unit_output_pin_o(pin_o),
    .unit_output_pin_oe(pin_oe), .special_event_trigger(trig), .adc_go_set(adc_go),
    .irq(irq));
  tcm_far_side far (.clk(clk), .resetn(resetn), .run(run), .div(8'h03), .pin_o(pin_o),
    .pin_oe(pin_oe), .adc_go_set(adc_go), .timer_tick(tick), .pin_level(pin_level),
    .adc_starts(adc_starts));

  always #50 clk = ~clk;

  // ==========================================================
  // register port tasks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  function automatic logic sel(input int w);
    return w == 0 ? irq : w == 1 ? ~trig : pin_level;
  endfunction

  task automatic wait_on(input int w);
    for (int k = 0; k < 100 && sel(w) !== 1'b1; k++) @(posedge clk);
    `CHK("wait", 1'b1, sel(w))
  endtask

  task automatic close_out;
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // read data monitor and timeout
  always @(posedge clk) begin
    if (rd_d) begin
      mon_e = exp_q.pop_front();
      `CHK("rdata", mon_e, rdata)
    end
    rd_d <= rd;
    cyc++;
    if (cyc >= 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [3:0]  ra[9];
    logic [7:0]  re[9];
    logic [3:0]  md[5];
    logic [15:0] m;
    logic        pe;
    logic [7:0]  adc_exp;
    int          k;
    ra = '{ADDR_CONTROL, ADDR_MATCH_LO, ADDR_MATCH_HI, ADDR_STATUS, ADDR_CLEAR,
           ADDR_ENABLE, ADDR_PERIOD, ADDR_TCTL, 4'hf};
    re = '{CONTROL_RESET, MATCH_RESET, MATCH_RESET, IRQ_RESET, READ_ZERO, IRQ_RESET,
           PERIOD_RESET, TCTL_RESET, READ_ZERO};
    md = '{MODE_SET, MODE_CLR, MODE_SET, MODE_SWI, MODE_SPECIAL};
    adc_exp = 8'h00;
    void'($urandom(6918));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i]) rd_reg(ra[i], re[i]);
    pin_direction_bit <= 1'b0;
    wr_reg(ADDR_TCTL, 8'h01);
    wr_reg(ADDR_ENABLE, 8'h04);
    foreach (md[i]) begin
      m = {8'($urandom), 8'($urandom_range(240, 3))};
      port_data_latch <= 1'($urandom);
      wr_reg(ADDR_CONTROL, 8'h00);
      wr_reg(ADDR_MATCH_LO, m[7:0]);
      wr_reg(ADDR_MATCH_HI, m[15:8]);
      wr_reg(ADDR_TMR_HI, m[15:8]);
      wr_reg(ADDR_TMR_LO, m[7:0] - 8'h03);
      wr_reg(ADDR_CLEAR, 8'hff);
      wr_reg(ADDR_CONTROL, {4'h0, md[i]});
      run <= 1'b1;
      wait_on(0);
      if (md[i] == MODE_SPECIAL) begin
        wait_on(1);
        adc_exp = adc_exp + 8'h01;
      end
      run <= 1'b0;
      pe = md[i] == MODE_SET ? 1'b1 : md[i] == MODE_CLR ? 1'b0 : port_data_latch;
      `CHK("pin_o", pe, pin_o)
      `CHK("adc_starts", adc_exp, adc_starts)
      rd_reg(ADDR_STATUS, 8'h04);
      if (md[i] == MODE_SPECIAL) rd_reg(ADDR_TMR_HI, 8'h00);
      wr_reg(ADDR_ENABLE, 8'h00);
      @(posedge clk);
      `CHK("irq", 1'b0, irq)
      wr_reg(ADDR_ENABLE, 8'h04);
    end
    // match removed before the timer tick
    wr_reg(ADDR_TMR_HI, m[15:8]);
    wr_reg(ADDR_TMR_LO, m[7:0]);
    repeat (2) @(posedge clk);
    `CHK("trigger", 1'b1, trig)
    `CHK("adc_starts", adc_exp + 8'h01, adc_starts)
    wr_reg(ADDR_MATCH_LO, m[7:0] - 8'h01);
    run <= 1'b1;
    repeat (12) @(posedge clk);
    run <= 1'b0;
    rd_reg(ADDR_TMR_HI, m[15:8]);
    rd_reg(ADDR_STATUS, 8'h04);
    wr_reg(ADDR_CLEAR, 8'h04);
    rd_reg(ADDR_STATUS, 8'h00);
    `CHK("irq", 1'b0, irq)
    // compare latch forced low by a zero control write
    port_data_latch <= 1'b1;
    wr_reg(ADDR_CONTROL, {4'h0, MODE_SET});
    wr_reg(ADDR_TMR_LO, m[7:0] - 8'h01);
    repeat (2) @(posedge clk);
    `CHK("pin_o", 1'b1, pin_o)
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_TMR_LO, m[7:0] - 8'h02);
    wr_reg(ADDR_CONTROL, {4'h0, MODE_SET});
    @(posedge clk);
    `CHK("pin_o", 1'b0, pin_o)
    // pwm: period 16 clocks, duty 8 clocks
    wr_reg(ADDR_PERIOD, 8'h03);
    wr_reg(ADDR_MATCH_LO, 8'h02);
    wr_reg(ADDR_CONTROL, 8'h0c);
    wait_on(2);
    k = 0;
    while (pin_level === 1'b1 && k < 50) begin
      k++;
      @(posedge clk);
    end
    `CHK("pwm_high", 8, k)
    wr_reg(ADDR_MATCH_HI, 8'h55);
    rd_reg(ADDR_MATCH_HI, 8'h02);
    wr_reg(ADDR_CONTROL, 8'h00);
    @(posedge clk);
    `CHK("pin_o", port_data_latch, pin_o)
    pin_direction_bit <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("pin_oe", 1'b0, pin_oe)
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule

// [logic/tcm_pkg.sv]
// tcm_pkg: register map, field positions, reset values and mode codes
// assumes an 8-bit register port with a 4-bit word address
package tcm_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_MATCH_LO = 4'h1;
  localparam logic [3:0] ADDR_MATCH_HI = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_CLEAR    = 4'h4;
  localparam logic [3:0] ADDR_ENABLE   = 4'h5;
  localparam logic [3:0] ADDR_TMR_LO   = 4'h6;
  localparam logic [3:0] ADDR_TMR_HI   = 4'h7;
  localparam logic [3:0] ADDR_PERIOD   = 4'h8;
  localparam logic [3:0] ADDR_TCTL     = 4'h9;

  // ==========================================================
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MATCH_RESET   = 8'h00;
  localparam logic [7:0] IRQ_RESET     = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hff;
  localparam logic [7:0] TCTL_RESET    = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // ==========================================================
  // field positions
  localparam int STAT_TMR_OVF  = 0;
  localparam int STAT_UNIT_IRQ = 2;
  localparam int TCTL_TIMER_ON = 0;
  localparam int CTL_DUTY_LSB  = 4;

  // ==========================================================
  // mode field codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLR     = 4'h9;
  localparam logic [3:0] MODE_SWI     = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;

  function automatic logic tcm_is_compare(input logic [3:0] mode);
    return mode[3:2] == 2'b10;
  endfunction

  function automatic logic tcm_is_pwm(input logic [3:0] mode);
    return mode[3:2] == 2'b11;
  endfunction

endpackage

// [logic/tcm_pwm.sv]
// tcm_pwm: 10-bit pwm time base with double-buffered duty
// assumes one time-base step per clk; period and duty may change at any time
`timescale 1ns/1ps
module tcm_pwm import tcm_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // setup
  input  wire logic       enable,
  input  wire logic [7:0] period,
  input  wire logic [9:0] duty,
  // results
  output logic            pwm_out,
  output logic      [7:0] duty_high
);

  logic [9:0] base;
  logic [1:0] duty_low;
  logic       wrap;
  logic       hit;

  assign wrap = (base[9:2] == period) && (base[1:0] == 2'b11);
  // falls on the edge where the base reaches the duty, so the pulse lasts duty clocks
  assign hit  = ((base + 10'h001) == {duty_high, duty_low});

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base      <= 10'h000;
      duty_high <= 8'h00;
      duty_low  <= 2'b00;
      pwm_out   <= 1'b0;
    end else if (!enable) begin
      base    <= 10'h000;
      pwm_out <= 1'b0;
    end else if (wrap) begin
      base      <= 10'h000;
      duty_high <= duty[9:2];
      duty_low  <= duty[1:0];
      pwm_out   <= (duty != 10'h000);
    end else begin
      base <= base + 10'h001;
      if (hit) begin
        pwm_out <= 1'b0;
      end
    end
  end

endmodule

// [logic/tcm_timer.sv]
// tcm_timer: sixteen_bit_timer with byte writes, overflow pulse and trigger clear
// assumes count_en is one cycle per timer clock edge, synchronous to clk
`timescale 1ns/1ps
module tcm_timer import tcm_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // counting
  input  wire logic        count_en,
  input  wire logic        clear_req,
  // software writes
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wdata,
  // state
  output logic      [15:0] value,
  output logic             overflow
);

  logic [15:0] value_next;
  logic        ovf_next;

  // clear replaces the increment, so no overflow is reported for it
  assign ovf_next   = count_en && !clear_req && (value == 16'hffff);
  assign value_next = wr_lo    ? {value[15:8], wdata} :
                      wr_hi    ? {wdata, value[7:0]} :
                      !count_en ? value :
                      clear_req ? 16'h0000 : value + 16'h0001;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value    <= 16'h0000;
      overflow <= 1'b0;
    end else begin
      value    <= value_next;
      overflow <= ovf_next;
    end
  end

endmodule

// [logic/tcm_top.sv]
// tcm_top: compare/pwm unit with register port, timer and pin hand-over
// assumes synchronous inputs, one-cycle strobes and a one-cycle timer tick
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module tcm_top import tcm_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // timer clock
  input  wire logic       timer_tick,
  // pin
  input  wire logic       pin_direction_bit,
  input  wire logic       port_data_latch,
  output logic            unit_output_pin_o,
  output logic            unit_output_pin_oe,
  // events
  output logic            special_event_trigger,
  output logic            adc_go_set,
  output logic            irq
);

  // ==========================================================
  // registers
  logic [7:0]  compare_unit_control_reg;
  logic [7:0]  match_value_low_reg;
  logic [7:0]  match_value_high_reg;
  logic [7:0]  peripheral_irq_flags_reg;
  logic [7:0]  peripheral_irq_flags_next;
  logic [7:0]  peripheral_irq_enable_reg;
  logic [7:0]  pwm_period_register_reg;
  logic [7:0]  period_timer_control_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        cmp_latch_reg;
  logic        cmp_latch_next;
  logic        match_eq_prev_reg;

  // ==========================================================
  // decode
  wire         wr_control = wr && (addr == ADDR_CONTROL);
  wire         wr_mlo     = wr && (addr == ADDR_MATCH_LO);
  wire         wr_mhi     = wr && (addr == ADDR_MATCH_HI);
  wire         wr_clear   = wr && (addr == ADDR_CLEAR);
  wire         wr_enable  = wr && (addr == ADDR_ENABLE);
  wire         wr_tlo     = wr && (addr == ADDR_TMR_LO);
  wire         wr_thi     = wr && (addr == ADDR_TMR_HI);
  wire         wr_period  = wr && (addr == ADDR_PERIOD);
  wire         wr_tctl    = wr && (addr == ADDR_TCTL);
  wire [3:0]   unit_mode_field = compare_unit_control_reg[3:0];
  wire         compare_mode    = tcm_is_compare(unit_mode_field);
  wire         pwm_mode        = tcm_is_pwm(unit_mode_field);
  wire         special_mode    = unit_mode_field == MODE_SPECIAL;

  // ==========================================================
  // timer and compare
  logic [15:0] sixteen_bit_timer;
  logic        timer_ovf;
  logic        pwm_out;
  logic [7:0]  pwm_duty_high;

  wire [15:0]  match_register_pair = {match_value_high_reg, match_value_low_reg};
  wire         match_eq  = compare_mode && (sixteen_bit_timer == match_register_pair);
  wire         cmp_hit   = match_eq && !match_eq_prev_reg;
  wire         timer_on  = period_timer_control_reg[TCTL_TIMER_ON];
  wire         count_en  = timer_on && timer_tick;
  // equality is looked at again on the tick, so a moved match skips the clear
  wire         clear_req = special_mode && match_eq;

  tcm_timer u_timer (
    .clk       (clk),
    .resetn    (resetn),
    .count_en  (count_en),
    .clear_req (clear_req),
    .wr_lo     (wr_tlo),
    .wr_hi     (wr_thi),
    .wdata     (wdata),
    .value     (sixteen_bit_timer),
    .overflow  (timer_ovf)
  );

  tcm_pwm u_pwm (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (pwm_mode),
    .period    (pwm_period_register_reg),
    .duty      ({match_value_low_reg, compare_unit_control_reg[CTL_DUTY_LSB +: 2]}),
    .pwm_out   (pwm_out),
    .duty_high (pwm_duty_high)
  );

  assign special_event_trigger = special_mode && match_eq;
  assign adc_go_set            = special_mode && cmp_hit;

  // ==========================================================
  // compare output latch
  always_comb begin
    cmp_latch_next = cmp_latch_reg;
    if (wr_control && (wdata == CONTROL_RESET)) begin
      cmp_latch_next = 1'b0;
    end else if (cmp_hit && (unit_mode_field == MODE_SET)) begin
      cmp_latch_next = 1'b1;
    end else if (cmp_hit && (unit_mode_field == MODE_CLR)) begin
      cmp_latch_next = 1'b0;
    end
  end

  // ==========================================================
  // pin hand-over: only set/clear compare and pwm take the pin
  wire unit_owns_pin = (unit_mode_field == MODE_SET) || (unit_mode_field == MODE_CLR)
                       || pwm_mode;
  wire pin_value     = pwm_mode ? pwm_out : cmp_latch_reg;

  assign unit_output_pin_oe = !pin_direction_bit;
  assign unit_output_pin_o  = unit_owns_pin ? pin_value : port_data_latch;

  // ==========================================================
  // interrupt flags: set wins over clear
  always_comb begin
    peripheral_irq_flags_next = peripheral_irq_flags_reg;
    if (wr_clear) begin
      peripheral_irq_flags_next = peripheral_irq_flags_reg & ~wdata;
    end
    if (cmp_hit) begin
      peripheral_irq_flags_next[STAT_UNIT_IRQ] = 1'b1;
    end
    if (timer_ovf) begin
      peripheral_irq_flags_next[STAT_TMR_OVF] = 1'b1;
    end
  end

  assign irq = |(peripheral_irq_flags_reg & peripheral_irq_enable_reg);

  // ==========================================================
  // read mux
  wire [7:0] match_high_view = pwm_mode ? pwm_duty_high : match_value_high_reg;
  always_comb begin
    case (addr)
      ADDR_CONTROL:  rdata_next = compare_unit_control_reg;
      ADDR_MATCH_LO: rdata_next = match_value_low_reg;
      ADDR_MATCH_HI: rdata_next = match_high_view;
      ADDR_STATUS:   rdata_next = peripheral_irq_flags_reg;
      ADDR_ENABLE:   rdata_next = peripheral_irq_enable_reg;
      ADDR_TMR_LO:   rdata_next = sixteen_bit_timer[7:0];
      ADDR_TMR_HI:   rdata_next = sixteen_bit_timer[15:8];
      ADDR_PERIOD:   rdata_next = pwm_period_register_reg;
      ADDR_TCTL:     rdata_next = period_timer_control_reg;
      default:       rdata_next = READ_ZERO;
    endcase
  end

  assign rdata = rdata_reg;

  // ==========================================================
  // register update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compare_unit_control_reg  <= CONTROL_RESET;
      match_value_low_reg       <= MATCH_RESET;
      match_value_high_reg      <= MATCH_RESET;
      peripheral_irq_flags_reg  <= IRQ_RESET;
      peripheral_irq_enable_reg <= IRQ_RESET;
      pwm_period_register_reg   <= PERIOD_RESET;
      period_timer_control_reg  <= TCTL_RESET;
      rdata_reg                 <= READ_ZERO;
      cmp_latch_reg             <= 1'b0;
      match_eq_prev_reg         <= 1'b0;
    end else begin
      peripheral_irq_flags_reg <= peripheral_irq_flags_next;
      cmp_latch_reg            <= cmp_latch_next;
      match_eq_prev_reg        <= match_eq;
      rdata_reg                <= rd ? rdata_next : READ_ZERO;
      if (wr_control) begin
        compare_unit_control_reg <= wdata;
      end
      if (wr_mlo) begin
        match_value_low_reg <= wdata;
      end
      if (wr_mhi && !pwm_mode) begin
        match_value_high_reg <= wdata;
      end
      if (wr_enable) begin
        peripheral_irq_enable_reg <= wdata;
      end
      if (wr_period) begin
        pwm_period_register_reg <= wdata;
      end
      if (wr_tctl) begin
        period_timer_control_reg <= wdata;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_trigger_same_cycle: assert property (
    (special_mode && sixteen_bit_timer == match_register_pair) |-> special_event_trigger)
    else $error("trigger missing in the cycle of equality");

  chk_flag_on_match: assert property (
    (compare_mode && sixteen_bit_timer == match_register_pair && !match_eq_prev_reg)
    |=> peripheral_irq_flags_reg[STAT_UNIT_IRQ])
    else $error("unit flag not set after match");

  chk_flag_sticky: assert property (
    (peripheral_irq_flags_reg[STAT_UNIT_IRQ] && !(wr_clear && wdata[STAT_UNIT_IRQ]))
    |=> peripheral_irq_flags_reg[STAT_UNIT_IRQ])
    else $error("unit flag dropped without a clear");

  chk_set_mode_high: assert property (
    (cmp_hit && unit_mode_field == MODE_SET && !wr_control) |=> cmp_latch_reg)
    else $error("set mode did not raise the latch");

  chk_clear_mode_low: assert property (
    (cmp_hit && unit_mode_field == MODE_CLR) |=> !cmp_latch_reg)
    else $error("clear mode did not lower the latch");

  chk_pin_left_port: assert property (
    (unit_mode_field == MODE_SWI || unit_mode_field == MODE_SPECIAL)
    |-> unit_output_pin_o == port_data_latch)
    else $error("unit took the pin in a pin-free mode");

  chk_timer_clears_tick: assert property (
    (special_event_trigger && count_en && !wr_tlo && !wr_thi)
    |=> sixteen_bit_timer == 16'h0000 && !timer_ovf)
    else $error("timer not cleared on tick after trigger");

  chk_moved_match_skip: assert property (
    (special_mode && !special_event_trigger && count_en && !wr_tlo && !wr_thi
     && sixteen_bit_timer != 16'hffff)
    |=> sixteen_bit_timer == $past(sixteen_bit_timer) + 16'h0001)
    else $error("timer cleared without a standing match");

  chk_zero_write_latch: assert property (
    (wr_control && wdata == CONTROL_RESET) |=> !cmp_latch_reg && !unit_owns_pin)
    else $error("zero control write left latch or pin held");

  chk_adc_start: assert property (
    (special_mode && cmp_hit) |-> adc_go_set ##1 !adc_go_set || special_event_trigger)
    else $error("adc start missing on special match");

  // ==========================================================
  // pin, flag and pulse checks
  chk_adc_one_pulse: assert property (
    adc_go_set |=> !adc_go_set)
    else $error("adc start held for more than one cycle");

  chk_special_pin_free: assert property (
    special_mode |-> unit_output_pin_o == port_data_latch)
    else $error("special trigger mode took the pin");

  chk_no_hit_off_mode: assert property (
    (!compare_mode && !peripheral_irq_flags_reg[STAT_UNIT_IRQ])
    |=> !peripheral_irq_flags_reg[STAT_UNIT_IRQ])
    else $error("unit flag raised outside compare mode");

  chk_no_ovf_on_clear: assert property (
    (clear_req && count_en && !timer_ovf && !peripheral_irq_flags_reg[STAT_TMR_OVF])
    |=> ##1 !peripheral_irq_flags_reg[STAT_TMR_OVF])
    else $error("trigger clear raised the overflow flag");

  chk_flag_clear_works: assert property (
    (wr_clear && wdata[STAT_UNIT_IRQ] && !cmp_hit)
    |=> !peripheral_irq_flags_reg[STAT_UNIT_IRQ])
    else $error("unit flag survived a clear without a match");

  chk_pwm_owns_pin: assert property (
    pwm_mode |-> unit_output_pin_o == pwm_out)
    else $error("pwm mode did not drive the waveform");

  chk_release_on_zero: assert property (
    (compare_unit_control_reg == CONTROL_RESET) |-> unit_output_pin_o == port_data_latch)
    else $error("cleared control still holds the pin");

  cov_set_match: cover property (cmp_hit && unit_mode_field == MODE_SET);
  cov_special_clear: cover property (special_event_trigger && count_en);
  cov_pwm_pulse: cover property (pwm_mode && $rose(pwm_out) ##[1:1000] $fell(pwm_out));
  cov_irq_out: cover property ($rose(irq));
  cov_moved_match: cover property (special_mode && special_event_trigger && wr_mlo);

endmodule
